// *** verilog/sagp_gpio_port.sv ***
// Purpose: Four shared analog/digital pins with static and PWM-coded readback
// Assumes: Pins arrive asynchronously; AXI4-Lite master keeps one access at a time
// Notes:   Pad output enable is active low (low = drive)
// Functional notes
// - Each pin is input or output by its own direction bit.
// - Input pins read static level or PWM-coded level per format bit.
// - No PWM is ever generated; outputs are always static.
// - Each PWM decoder has its own two-bit timebase select.
// - Pin is digital only while voltage ADC off and digital select set.
// - ADC enabled forces both shared pins analog, drivers off.
// - Output pin drives the level of its output bit.
// - Outputs are push-pull, never open-drain.
// - Every pin is sampled continuously into its two-bit readback field.
// - Readback is 00b while the pin acts as analog input.
// - PWM decoder classifies input into one of four levels.
// - Readback may need up to two PWM cycles after a change.
// - Timebase value 3h selects 1024 main-clock periods.
module sagp_gpio_port
   import sagp_pkg::*;
#(
   parameter int unsigned PINS = NUM_PINS
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Pads
   input  wire logic [PINS-1:0]     padIn,
   output logic      [PINS-1:0]     padOut,
   output logic      [PINS-1:0]     padOutEnN,
   output logic      [PINS-1:0]     padDigital
);

   // ****************************************
   // Register bus
   // ****************************************
   logic [31:0]      pinCfg_r, pinCfg_nxt;
   logic [31:0]      sideCfg_r, sideCfg_nxt;
   logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
   logic [31:0]      wData_r, wData_nxt;
   logic [3:0]       wStrb_r, wStrb_nxt;
   logic             awHave_r, awHave_nxt, wHave_r, wHave_nxt;
   logic             bValid_r, bValid_nxt, rValid_r, rValid_nxt;
   logic [1:0]       bResp_r, bResp_nxt, rResp_r, rResp_nxt;
   logic [31:0]      rData_r, rData_nxt;
   logic [2*PINS-1:0] readback;

   assign s_axi_awready = !awHave_r && !bValid_r;
   assign s_axi_wready  = !wHave_r && !bValid_r;
   assign s_axi_arready = !rValid_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rresp   = rResp_r;
   assign s_axi_rdata   = rData_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            res[8*b +: 8] = d[8*b +: 8];
         end
      end
      return res;
   endfunction

   always_comb begin
      pinCfg_nxt  = pinCfg_r;
      sideCfg_nxt = sideCfg_r;
      awAddr_nxt  = awAddr_r;
      wData_nxt   = wData_r;
      wStrb_nxt   = wStrb_r;
      awHave_nxt  = awHave_r;
      wHave_nxt   = wHave_r;
      bValid_nxt  = bValid_r;
      bResp_nxt   = bResp_r;
      rValid_nxt  = rValid_r;
      rResp_nxt   = rResp_r;
      rData_nxt   = rData_r;
      if (s_axi_awvalid && s_axi_awready) begin
         awAddr_nxt = s_axi_awaddr;
         awHave_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
         wHave_nxt = 1'b1;
      end
      // Both halves held: commit the write one cycle after the later one
      if (awHave_r && wHave_r) begin
         awHave_nxt = 1'b0;
         wHave_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt  = RESP_OKAY;
         case ({awAddr_r[ADDR_W-1:2], 2'b00})
            OFS_PIN_CFG:  pinCfg_nxt  = merge(pinCfg_r, wData_r, wStrb_r);
            OFS_SIDE_CFG: sideCfg_nxt = merge(sideCfg_r, wData_r, wStrb_r);
            OFS_READBACK: bResp_nxt   = RESP_OKAY;
            default:      bResp_nxt   = RESP_SLVERR;
         endcase
      end
      if (bValid_r && s_axi_bready) begin
         bValid_nxt = 1'b0;
      end
      if (rValid_r && s_axi_rready) begin
         rValid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_nxt = 1'b1;
         rResp_nxt  = RESP_OKAY;
         case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            OFS_PIN_CFG:  rData_nxt = pinCfg_r;
            OFS_SIDE_CFG: rData_nxt = sideCfg_r;
            OFS_READBACK: rData_nxt = {{(32-2*PINS){1'b0}}, readback};
            default: begin
               rData_nxt = 32'h0000_0000;
               rResp_nxt = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pinCfg_r  <= RST_PIN_CFG;
         sideCfg_r <= RST_SIDE_CFG;
         awAddr_r  <= '0;
         wData_r   <= 32'h0000_0000;
         wStrb_r   <= 4'h0;
         awHave_r  <= 1'b0;
         wHave_r   <= 1'b0;
         bValid_r  <= 1'b0;
         bResp_r   <= RESP_OKAY;
         rValid_r  <= 1'b0;
         rResp_r   <= RESP_OKAY;
         rData_r   <= 32'h0000_0000;
      end else begin
         pinCfg_r  <= pinCfg_nxt;
         sideCfg_r <= sideCfg_nxt;
         awAddr_r  <= awAddr_nxt;
         wData_r   <= wData_nxt;
         wStrb_r   <= wStrb_nxt;
         awHave_r  <= awHave_nxt;
         wHave_r   <= wHave_nxt;
         bValid_r  <= bValid_nxt;
         bResp_r   <= bResp_nxt;
         rValid_r  <= rValid_nxt;
         rResp_r   <= rResp_nxt;
         rData_r   <= rData_nxt;
      end
   end

   // ****************************************
   // Timebase enables
   // ****************************************
   // One free-running counter; bit k toggles every 2^k cycles
   logic [10:0] tbCnt_r, tbCnt_nxt;
   logic [3:0]  tbTick;

   assign tbCnt_nxt = tbCnt_r + 11'h001;
   // Units are powers of two, so one counter's low bits serve all four
   assign tbTick[0] = (tbCnt_r[6:0] == 7'(TB_UNIT0 - 1));
   assign tbTick[1] = (tbCnt_r[7:0] == 8'(TB_UNIT1 - 1));
   assign tbTick[2] = (tbCnt_r[8:0] == 9'(TB_UNIT2 - 1));
   assign tbTick[3] = (tbCnt_r[9:0] == 10'(TB_UNIT3 - 1));

   always_ff @(posedge clk) begin
      if (srst) begin
         tbCnt_r <= 11'h000;
      end else begin
         tbCnt_r <= tbCnt_nxt;
      end
   end

   // ****************************************
   // Pin synchronisers and pad control
   // ****************************************
   logic [PINS-1:0] sync1_r, sync2_r, syncPrev_r;
   logic [PINS-1:0] digital;

   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r    <= '0;
         sync2_r    <= '0;
         syncPrev_r <= '0;
      end else begin
         sync1_r    <= padIn;
         sync2_r    <= sync1_r;
         syncPrev_r <= sync2_r;
      end
   end

   for (genvar p = 0; p < PINS; p++) begin : g_pin
      sagp_pin_cfg_s cfg;
      logic          side;
      sagp_pwm_e     st_r, st_nxt;
      logic [CNT_W-1:0] lowCnt_r, lowCnt_nxt, highCnt_r, highCnt_nxt;
      logic [1:0]    pwmCode_r, pwmCode_nxt;
      logic          tick;
      logic [CNT_W:0] period;
      logic [1:0]    rbCode;

      assign cfg  = sagp_pin_cfg_s'(pinCfg_r[8*p +: 5]);
      assign side = (p >= PINS/2);
      assign tick = tbTick[cfg.pwmDecodeTimebase];
      // ADC enable overrides the digital select for both pins of a side
      assign digital[p] = !sideCfg_r[FLD_ADC_A + side]
                          && sideCfg_r[FLD_SEL_A + side];
      // Push-pull: value driven both ways, static level only
      assign padOut[p]    = cfg.outputLevelBit;
      assign padOutEnN[p] = !(digital[p] && cfg.pinDirectionSel);
      assign padDigital[p] = digital[p];

      // Measure high and low time in timebase units; a rising edge closes a period
      always_comb begin
         st_nxt      = st_r;
         lowCnt_nxt  = lowCnt_r;
         highCnt_nxt = highCnt_r;
         pwmCode_nxt = pwmCode_r;
         period      = {1'b0, lowCnt_r} + {1'b0, highCnt_r};
         case (st_r)
            SAGP_WAIT: begin
               if (sync2_r[p] && !syncPrev_r[p]) begin
                  st_nxt      = SAGP_HIGHP;
                  highCnt_nxt = '0;
               end
            end
            SAGP_HIGHP: begin
               if (!sync2_r[p]) begin
                  st_nxt     = SAGP_LOWP;
                  lowCnt_nxt = '0;
               end else if (tick && highCnt_r != '1) begin
                  highCnt_nxt = highCnt_r + 1'b1;
               end
            end
            SAGP_LOWP: begin
               if (sync2_r[p]) begin
                  // Quarter the duty cycle into four levels
                  st_nxt      = SAGP_HIGHP;
                  highCnt_nxt = '0;
                  if (period == '0) begin
                     pwmCode_nxt = 2'h0;
                  end else if ({highCnt_r, 2'b00} < {1'b0, period}) begin
                     pwmCode_nxt = 2'h0;
                  end else if ({highCnt_r, 1'b0} < period) begin
                     pwmCode_nxt = 2'h1;
                  end else if ({1'b0, highCnt_r, 2'b00}
                               < {1'b0, period, 1'b0} + {2'b00, period}) begin
                     pwmCode_nxt = 2'h2;
                  end else begin
                     pwmCode_nxt = 2'h3;
                  end
               end else if (tick && lowCnt_r != '1) begin
                  lowCnt_nxt = lowCnt_r + 1'b1;
               end
            end
            default: st_nxt = SAGP_WAIT;
         endcase
      end

      always_ff @(posedge clk) begin
         if (srst) begin
            st_r      <= SAGP_WAIT;
            lowCnt_r  <= '0;
            highCnt_r <= '0;
            pwmCode_r <= CODE_LOW;
         end else begin
            st_r      <= st_nxt;
            lowCnt_r  <= lowCnt_nxt;
            highCnt_r <= highCnt_nxt;
            pwmCode_r <= pwmCode_nxt;
         end
      end

      // Readback always live; analog pins read zero
      always_comb begin
         if (!digital[p]) begin
            rbCode = CODE_LOW;
         end else if (cfg.inputFormatSel && !cfg.pinDirectionSel) begin
            rbCode = pwmCode_r;
         end else begin
            rbCode = sync2_r[p] ? CODE_HIGH : CODE_LOW;
         end
      end
      assign readback[2*p +: 2] = rbCode;
   end

endmodule

// *** include/sagp_pkg.sv ***
// Purpose: Shared constants and types for the shared analog GPIO port
// Assumes: 10 MHz main clock, AXI4-Lite register access with 32-bit data
// Notes:   Four pins, two per side; side A is pins 0/1, side B is pins 2/3
package sagp_pkg;

   // ****************************************
   // Geometry and register map
   // ****************************************
   localparam int unsigned NUM_PINS      = 4;
   localparam int unsigned ADDR_W        = 8;
   localparam logic [7:0]  OFS_PIN_CFG   = 8'h00;
   localparam logic [7:0]  OFS_SIDE_CFG  = 8'h04;
   localparam logic [7:0]  OFS_READBACK  = 8'h08;
   // Per-pin config byte layout: lane i holds pin i
   localparam int unsigned FLD_DIR       = 0;
   localparam int unsigned FLD_FMT       = 1;
   localparam int unsigned FLD_OUT       = 2;
   localparam int unsigned FLD_TB_LO     = 3;
   // Side config: bit0/1 digital select A/B, bit8/9 voltage ADC enable A/B
   localparam int unsigned FLD_SEL_A     = 0;
   localparam int unsigned FLD_ADC_A     = 8;
   localparam logic [31:0] RST_PIN_CFG   = 32'h0000_0000;
   localparam logic [31:0] RST_SIDE_CFG  = 32'h0000_0000;

   // ****************************************
   // Readback codes and timing
   // ****************************************
   localparam logic [1:0]  CODE_LOW      = 2'h0;
   localparam logic [1:0]  CODE_HIGH     = 2'h3;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // Timebase unit per select value in main-clock periods
   localparam int unsigned TB_UNIT0      = 128;
   localparam int unsigned TB_UNIT1      = 256;
   localparam int unsigned TB_UNIT2      = 512;
   localparam int unsigned TB_UNIT3      = 1024;
   localparam int unsigned CNT_W         = 20;

   typedef struct packed {
      logic [1:0] pwmDecodeTimebase;
      logic       outputLevelBit;
      logic       inputFormatSel;
      logic       pinDirectionSel;
   } sagp_pin_cfg_s;

   typedef enum logic [1:0] {
      SAGP_WAIT  = 2'b00,
      SAGP_LOWP  = 2'b01,
      SAGP_HIGHP = 2'b11
   } sagp_pwm_e;

endpackage

// *** verif/sagp_pin_model.sv ***
// Purpose: Far-side model of the four pads, static or PWM source
// Assumes: One PWM waveform shared by every pin picked in pwmSel
// Notes:   A pad the device drives reads back its own level
module sagp_pin_model (
   // Clock
   input  wire logic        clk,
   // Device pad side
   input  wire logic [3:0]  padOut,
   input  wire logic [3:0]  padOutEnN,
   output logic      [3:0]  padIn,
   // Source setup
   input  wire logic [3:0]  extLevel,
   input  wire logic [3:0]  pwmSel,
   input  wire logic [19:0] pwmPeriod,
   input  wire logic [19:0] pwmHigh
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [19:0] phase = 20'h0;
   logic        pwmWave;
   // Period is a whole number of decoder units, never faster
   always @(posedge clk) phase <= (phase >= pwmPeriod - 20'h1) ? 20'h0 : phase + 20'h1;
   assign pwmWave = phase < pwmHigh;
   // Driven pad wins in both levels
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         padIn[i] = !padOutEnN[i] ? padOut[i] : (pwmSel[i] ? pwmWave : extLevel[i]);
      end
   end
endmodule

// *** verif/sagp_gpio_port_assertions.sv ***
// Purpose: Port-level checks of the shared analog GPIO port
// Assumes: Pad mode and level change only as a write commits
// Notes:   Bound into every instance of the port
module sagp_gpio_port_assertions
   import sagp_pkg::*;
#(
   parameter int unsigned PINS = NUM_PINS
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              srst,
   // Bus
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   // Pads
   input wire logic [PINS-1:0]   padOut,
   input wire logic [PINS-1:0]   padOutEnN,
   input wire logic [PINS-1:0]   padDigital
);
   logic [2:0] wrAge_r, wrAge_nxt;
   logic [7:0] anaMask_r, anaMask_nxt;
   logic       arTake;
   assign arTake = s_axi_arvalid && s_axi_arready;
   // Cycles since last write data taken, saturating
   always_comb begin
      wrAge_nxt = (s_axi_wvalid && s_axi_wready) ? 3'h0 : wrAge_r + {2'h0, wrAge_r != 3'h7};
      anaMask_nxt = anaMask_r;
      if (arTake) begin
         for (int i = 0; i < 4; i++) anaMask_nxt[2*i +: 2] = {2{~padDigital[i]}};
      end
   end
   always_ff @(posedge clk) begin
      wrAge_r <= srst ? 3'h7 : wrAge_nxt;
      anaMask_r <= anaMask_nxt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   drive_needs_digital_a: assert property ((~padOutEnN & ~padDigital) == '0)
      else $error("pad driven while analog");
   pad_static_a: assert property ($changed(padOut) |-> wrAge_r <= 3'h4)
      else $error("pad level moved without a write");
   pad_mode_a: assert property ($changed(padOutEnN) || $changed(padDigital) |-> wrAge_r <= 3'h4)
      else $error("pad mode moved without a write");
   push_pull_a: assert property ((~$past(padOutEnN) & (padOut ^ $past(padOut)) & padOutEnN) == '0)
      else $error("driver released on level change");
   analog_zero_a: assert property (arTake && s_axi_araddr == OFS_READBACK |=> (s_axi_rdata[7:0] & anaMask_r) == 8'h00)
      else $error("analog pin readback not zero");
   read_answer_a: assert property (arTake |=> s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   bad_read_a: assert property (arTake && s_axi_araddr[ADDR_W-1:2] > OFS_READBACK[ADDR_W-1:2]
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   reset_idle_a: assert property (@(posedge clk) disable iff (1'b0) srst |=> padDigital == '0 && padOutEnN == '1)
      else $error("pads not analog in reset");
endmodule
bind sagp_gpio_port sagp_gpio_port_assertions #(.PINS(PINS)) sagp_gpio_port_assertions_i (
   .clk(clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .padOut(padOut), .padOutEnN(padOutEnN), .padDigital(padDigital));

// *** verif/tb.sv ***
// Purpose: Self-checking bench of the shared analog GPIO port
// Assumes: Bus tasks start right after a rising edge
// Notes:   Readiness is looked at on the falling edge to avoid races
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sagp_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
   logic clk = 1'b0, srst = 1'b1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [3:0] padIn, padOut, padOutEnN, padDigital, extLevel = 4'h0, pwmSel = 4'h0;
   logic [19:0] pwmPeriod = 20'd1024, pwmHigh = 20'd0;
   int n_mismatch = 0, compares = 0;
   initial forever #50 clk = ~clk;
   sagp_gpio_port sagp_gpio_port_i (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .padIn(padIn), .padOut(padOut), .padOutEnN(padOutEnN),
      .padDigital(padDigital));
   sagp_pin_model sagp_pin_model_i (.clk(clk), .padOut(padOut), .padOutEnN(padOutEnN),
      .padIn(padIn), .extLevel(extLevel), .pwmSel(pwmSel), .pwmPeriod(pwmPeriod),
      .pwmHigh(pwmHigh));
   task automatic wrap_up;
      $display("n_mismatch %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw = 1'b0, w = 1'b0, b = 1'b0;
      logic [1:0] rsp = 2'h0;
      // Write response ready simply stays up between writes
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (int n = 0; n < 40 && !b; n++) begin
         @(negedge clk);
         aw = aw | (awvalid & awready);
         w = w | (wvalid & wready);
         b = bvalid;
         rsp = bresp;
         @(posedge clk);
         if (aw && awvalid) awvalid <= 1'b0;
         if (w && wvalid) wvalid <= 1'b0;
      end
      if (!b) begin n_mismatch++; wrap_up; end
      `CHK(rsp, RESP_OKAY);
   endtask
   task automatic rd(input logic [7:0] a);
      logic ar = 1'b0, rv = 1'b0, seen = 1'b0;
      // Read ready comes one cycle after valid, so a held answer is exercised
      araddr <= a; arvalid <= 1'b1;
      for (int n = 0; n < 40 && !rv; n++) begin
         @(negedge clk);
         ar = ar | (arvalid & arready);
         rv = rvalid & rready;
         seen = rvalid;
         d = rdata; r = rresp;
         @(posedge clk);
         if (ar && arvalid) arvalid <= 1'b0;
         rready <= seen & !rv;
      end
      if (!rv) begin n_mismatch++; wrap_up; end
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_reset;
      `CHK(padDigital, 4'h0);
      `CHK(padOutEnN, 4'hf);
      rd(OFS_PIN_CFG); `CHK(d, RST_PIN_CFG);
      rd(OFS_SIDE_CFG); `CHK(d, RST_SIDE_CFG);
      rd(8'h0c); `CHK(r, RESP_SLVERR); `CHK(d, 32'h0);
      wr(OFS_READBACK, 32'hffff_ffff); rd(OFS_READBACK); `CHK(d, 32'h0);
   endtask
   task automatic t_side;
      wr(OFS_SIDE_CFG, 32'h0000_0203); settle; `CHK(padDigital, 4'h3);
      wr(OFS_SIDE_CFG, 32'h0000_0102); settle; `CHK(padDigital, 4'hc);
      wr(OFS_SIDE_CFG, 32'h0000_0003); settle; `CHK(padDigital, 4'hf);
   endtask
   task automatic t_out;
      extLevel <= 4'h7;
      wr(OFS_PIN_CFG, 32'h001f_0305); settle;
      `CHK(padOutEnN, 4'h8);
      `CHK(padOut[2:0], 3'h5);
      rd(OFS_READBACK); `CHK(d[7:0], 8'h33);
      wr(OFS_PIN_CFG, 32'h001f_0701); settle;
      `CHK(padOutEnN, 4'h8);
      `CHK(padOut[2:0], 3'h6);
      rd(OFS_READBACK); `CHK(d[7:0], 8'h3c);
      wr(OFS_SIDE_CFG, 32'h0000_0203); settle;
      `CHK(padOutEnN[2], 1'b1);
      rd(OFS_READBACK); `CHK(d[7:0], 8'h0c);
   endtask
   task automatic t_pwm;
      wr(OFS_SIDE_CFG, 32'h3); wr(OFS_PIN_CFG, 32'h0004_0600);
      extLevel <= 4'h1; pwmSel <= 4'h2;
      for (int k = 0; k < 4; k++) begin
         pwmHigh <= 20'((2 * k + 1) * 128);
         repeat (3 * 1024) @(posedge clk);
         rd(OFS_READBACK); `CHK(d[3:0], {2'(k), CODE_HIGH});
      end
      wr(OFS_PIN_CFG, 32'h0a12_021a); pwmSel <= 4'hf; pwmPeriod <= 20'd8192; pwmHigh <= 20'd5120;
      repeat (3 * 8192) @(posedge clk);
      rd(OFS_READBACK); `CHK(d[7:0], 8'haa);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset; t_side; t_out; t_pwm;
      wrap_up;
   end
endmodule
